// >>> core/psr_register_bank.sv
// Paged status, cause and event register bank behind the 2-wire host.
// Assumes a byte-level front end on the link clock and pulse-style
// cause and event sources on clk_i.
//
// What this block does
// - Page field bits 1:0 form the top two bits of every access address.
// - Pages 00,01,10,11 select 0x000, 0x080, 0x100, 0x180 blocks.
// - One-shot bit set returns the page to zero after one access outside window select.
// - Write style 0 increments addresses, style 1 uses address/data pairs.
// - Window select sits at offset zero of every page, one shared copy.
// - Status shows ramping in bit 2 and power key level in bit 0.
// - Cause record latches wait timeout, reset request, power key.
// - Bit 3 early supply under-voltage within 16 s; bit 2 any.
// - Bit 4 critical heat, bit 1 cold start, bit 0 watchdog expiry.
// - Writing ones clears cause bits; zero bits stay.
// - Primary bits 6 and 5 summarise pin and supply events, read-only.
// - Primary events latch sequencer, watchdog warning, tick, alarm, key.
// - Supply events latch bits 7, 5, 3, 1; others read zero.
// - Event flags clear on writing one; zero leaves them.
// - Primary masks bits 4:0 gate matching events off the request.
// - Supply masks bits 7, 5, 3, 1 align with their events.
// - Pin masks bits 4:0 gate the five input events.
`timescale 1ns/1ps
`default_nettype none
`include "psr_consts.svh"

module psr_register_bank
    import psr_pkg::*;
#(
    parameter logic [31:0] UV_WINDOW_CYC = 32'(`PSR_UV_WINDOW_CYC)
) (
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          link_clk_i,
    input  wire logic          lnk_frame_i,
    input  wire logic          lnk_byte_valid_i,
    input  wire logic [7:0]    lnk_byte_i,
    input  wire logic          lnk_read_i,
    output logic               lnk_ready_o,
    output logic               lnk_rd_valid_o,
    output logic [7:0]         lnk_rd_data_o,
    input  wire logic          voltage_ramp_active_i,
    input  wire logic          power_key_input_i,
    input  wire logic [4:0]    gen_input_i,
    input  wire logic [3:0]    regulator_overcurrent_i,
    input  wire logic          system_reset_output_n_i,
    input  wire psr_cause_type cause_i,
    input  wire psr_event_type event_i,
    output logic               irq_o
);

    // Link-domain reset and write style, core-domain pin input synchronisers
    logic       lrst_s1_q;
    logic       lrst_n_q;
    logic       style_s1_q;
    logic       style_q;
    logic       key_s1_q;
    logic       key_q;
    logic [4:0] gin_s1_q;
    logic [4:0] gin_q;
    logic [4:0] gin_prev_q;

    // Core-domain registers
    logic [7:0]  win_sel_q;
    logic [7:0]  cause_q;
    logic [4:0]  pri_ev_q;
    logic [7:0]  sup_ev_q;
    logic [4:0]  pin_ev_q;
    logic [7:0]  pri_mask_q;
    logic [7:0]  sup_mask_q;
    logic [7:0]  pin_mask_q;
    logic [31:0] uv_win_q;

    // Link-domain parser
    psr_link_state_type lstate_q;
    logic [6:0]         loff_q;
    logic               lreq_valid;
    psr_access_type     lreq;
    logic               lreq_busy;
    logic               lrep_valid;
    logic [7:0]         lrep_data;
    logic               lwait_q;
    logic               lread_q;

    // Core-domain access
    logic           acc_valid;
    psr_access_type acc;
    logic [8:0]     acc_addr;
    logic           acc_wr;
    logic           acc_win;
    logic [7:0]     rd_data;
    logic           rep_busy;
    logic [7:0]     pri_view;

    // Reset into the link clock; sync1 feeds sync2 only
    always_ff @(posedge link_clk_i) begin
        lrst_s1_q <= rst_n_i;
        lrst_n_q  <= lrst_s1_q;
    end

    // Write style is a quasi-static level, so two flops carry it
    always_ff @(posedge link_clk_i) begin
        if (!lrst_n_q) begin
            style_s1_q <= 1'b0;
            style_q    <= 1'b0;
        end else begin
            style_s1_q <= win_sel_q[`PSR_BIT_WRITE_STYLE];
            style_q    <= style_s1_q;
        end
    end

    // Byte parser: first byte of a frame is the in-page offset
    always_ff @(posedge link_clk_i) begin
        if (!lrst_n_q || !lnk_frame_i) begin
            lstate_q <= PSR_ST_ADDR;
            loff_q   <= 7'h00;
        end else if (lnk_byte_valid_i && lnk_ready_o) begin
            unique case (lstate_q)
                PSR_ST_ADDR: begin
                    loff_q   <= lnk_byte_i[6:0];
                    lstate_q <= PSR_ST_DATA;
                end
                PSR_ST_DATA: begin
                    if (style_q) begin
                        lstate_q <= PSR_ST_ADDR;
                    end else begin
                        loff_q <= loff_q + 7'h01;
                    end
                end
            endcase
        end else if (lnk_read_i && lnk_ready_o) begin
            loff_q <= loff_q + 7'h01;
        end
    end

    // Writes leave on a data byte, reads on a read strobe
    always_comb begin
        lreq.write  = lnk_byte_valid_i;
        lreq.offset = loff_q;
        lreq.data   = lnk_byte_i;
        lreq_valid  = lnk_ready_o && lnk_frame_i
                      && ((lnk_byte_valid_i && lstate_q == PSR_ST_DATA)
                          || (lnk_read_i && !lnk_byte_valid_i));
    end

    // Hold off the host until the access has been done in the core
    always_ff @(posedge link_clk_i) begin
        if (!lrst_n_q) begin
            lwait_q <= 1'b0;
            lread_q <= 1'b0;
        end else if (lreq_valid) begin
            lwait_q <= 1'b1;
            lread_q <= !lreq.write;
        end else if (lread_q ? lrep_valid : !lreq_busy) begin
            lwait_q <= 1'b0;
            lread_q <= 1'b0;
        end
    end

    assign lnk_ready_o = !lwait_q && !lreq_busy;

    // Read answers are registered toward the host
    always_ff @(posedge link_clk_i) begin
        if (!lrst_n_q) begin
            lnk_rd_valid_o <= 1'b0;
            lnk_rd_data_o  <= 8'h00;
        end else begin
            lnk_rd_valid_o <= lrep_valid && lread_q;
            if (lrep_valid) begin
                lnk_rd_data_o <= lrep_data;
            end
        end
    end

    psr_word_cdc #(.WIDTH(16)) u_req_cdc (
        .src_clk_i   (link_clk_i),
        .src_rst_n_i (lrst_n_q),
        .src_valid_i (lreq_valid),
        .src_data_i  (lreq),
        .src_busy_o  (lreq_busy),
        .dst_clk_i   (clk_i),
        .dst_rst_n_i (rst_n_i),
        .dst_valid_o (acc_valid),
        .dst_data_o  (acc)
    );

    psr_word_cdc #(.WIDTH(8)) u_rep_cdc (
        .src_clk_i   (clk_i),
        .src_rst_n_i (rst_n_i),
        .src_valid_i (acc_valid && !acc.write),
        .src_data_i  (rd_data),
        .src_busy_o  (rep_busy),
        .dst_clk_i   (link_clk_i),
        .dst_rst_n_i (lrst_n_q),
        .dst_valid_o (lrep_valid),
        .dst_data_o  (lrep_data)
    );

    // Page bits on top of the in-page offset
    always_comb begin
        acc_addr = {win_sel_q[`PSR_PAGE_HI:`PSR_PAGE_LO], acc.offset};
        acc_win  = (acc.offset == `PSR_OFF_WINDOW_SEL);
        acc_wr   = acc_valid && acc.write;
    end

    // Pin inputs pass two flops before any logic reads them
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            key_s1_q   <= 1'b0;
            key_q      <= 1'b0;
            gin_s1_q   <= 5'h00;
            gin_q      <= 5'h00;
            gin_prev_q <= 5'h00;
        end else begin
            key_s1_q   <= power_key_input_i;
            key_q      <= key_s1_q;
            gin_s1_q   <= gen_input_i;
            gin_q      <= gin_s1_q;
            gin_prev_q <= gin_q;
        end
    end

    // Window select; all mirrors map to this one register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            win_sel_q <= `PSR_RST_WINDOW_SEL;
        end else if (acc_valid && acc_win) begin
            if (acc.write) begin
                win_sel_q <= acc.data;
            end
        end else if (acc_valid && win_sel_q[`PSR_BIT_ONE_SHOT]) begin
            // Other accesses drop back to page zero once
            win_sel_q[`PSR_PAGE_HI:`PSR_PAGE_LO] <= 2'b00;
        end
    end

    // Early window: held during reset output, then counted down
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !system_reset_output_n_i) begin
            uv_win_q <= UV_WINDOW_CYC;
        end else if (uv_win_q != 32'h00000000) begin
            uv_win_q <= uv_win_q - 32'h00000001;
        end
    end

    // Cause record: a new cause wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cause_q <= `PSR_RST_FLAGS;
        end else begin
            cause_q <= (cause_q & ~((acc_wr && acc_addr ==
                       {2'b00, `PSR_OFF_CAUSE_REC}) ? acc.data : 8'h00))
                     | {cause_i.wait_timeout,
                        cause_i.reset_request_cause,
                        cause_i.key_reset,
                        cause_i.critical_heat_cause,
                        cause_i.supply_uv_shutdown
                            && (uv_win_q != 32'h00000000),
                        cause_i.supply_uv_shutdown,
                        cause_i.cold_start,
                        cause_i.watchdog_expiry_cause};
        end
    end

    // Event flags: set wins over a write-one clear
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pri_ev_q <= 5'h00;
            sup_ev_q <= `PSR_RST_FLAGS;
            pin_ev_q <= 5'h00;
        end else begin
            pri_ev_q <= (pri_ev_q & ~((acc_wr && acc_addr ==
                        {2'b00, `PSR_OFF_PRI_EVENTS}) ? acc.data[4:0]
                        : 5'h00))
                      | {event_i.sequencer_done_flag,
                         event_i.watchdog_warning_flag,
                         event_i.rtc_tick,
                         event_i.rtc_alarm,
                         event_i.power_key_flag};
            sup_ev_q <= ((sup_ev_q & ~((acc_wr && acc_addr ==
                        {2'b00, `PSR_OFF_SUP_EVENTS}) ? acc.data
                        : 8'h00))
                      | {event_i.supply_uv_warning, 1'b0,
                         event_i.ramp_complete_flag, 1'b0,
                         event_i.regulator_overload_flag, 1'b0,
                         event_i.heat_warning, 1'b0})
                      & `PSR_SUP_EVENT_BITS;
            pin_ev_q <= (pin_ev_q & ~((acc_wr && acc_addr ==
                        {2'b00, `PSR_OFF_PIN_EVENTS}) ? acc.data[4:0]
                        : 5'h00))
                      | (gin_q ^ gin_prev_q);
        end
    end

    // Mask registers keep all eight bits as written
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pri_mask_q <= `PSR_RST_MASKS;
            sup_mask_q <= `PSR_RST_MASKS;
            pin_mask_q <= `PSR_RST_MASKS;
        end else if (acc_wr) begin
            if (acc_addr == {2'b00, `PSR_OFF_PRI_MASKS}) begin
                pri_mask_q <= acc.data;
            end
            if (acc_addr == {2'b00, `PSR_OFF_SUP_MASKS}) begin
                sup_mask_q <= acc.data;
            end
            if (acc_addr == {2'b00, `PSR_OFF_PIN_MASKS}) begin
                pin_mask_q <= acc.data;
            end
        end
    end

    // Summaries are live, so they fall as soon as the flags clear
    always_comb begin
        pri_view = {1'b0, |pin_ev_q, |sup_ev_q, 5'h00}
                 | {3'b000, pri_ev_q};
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        rd_data = 8'h00;
        if (acc_win) begin
            rd_data = win_sel_q;
        end else begin
            unique case (acc_addr)
                {2'b00, `PSR_OFF_PM_STATUS}:
                    rd_data = {5'h00, voltage_ramp_active_i,
                               1'b0, key_q};
                {2'b00, `PSR_OFF_PIN_LEVELS}:
                    rd_data = {3'b000, gin_q};
                {2'b00, `PSR_OFF_OVC_STATUS}:
                    rd_data = {4'h0, regulator_overcurrent_i};
                {2'b00, `PSR_OFF_CAUSE_REC}:  rd_data = cause_q;
                {2'b00, `PSR_OFF_PRI_EVENTS}: rd_data = pri_view;
                {2'b00, `PSR_OFF_SUP_EVENTS}: rd_data = sup_ev_q;
                {2'b00, `PSR_OFF_PIN_EVENTS}: rd_data = {3'b000, pin_ev_q};
                {2'b00, `PSR_OFF_PRI_MASKS}:  rd_data = pri_mask_q;
                {2'b00, `PSR_OFF_SUP_MASKS}:  rd_data = sup_mask_q;
                {2'b00, `PSR_OFF_PIN_MASKS}:  rd_data = pin_mask_q;
                default:                      rd_data = 8'h00;
            endcase
        end
    end

    // Request line registered so it is glitch free at the pin
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(pri_ev_q & ~pri_mask_q[4:0])
                   | |(sup_ev_q & ~sup_mask_q)
                   | |(pin_ev_q & ~pin_mask_q[4:0]);
        end
    end

endmodule

`default_nettype wire

// >>> shared/psr_consts.svh
// Offsets, field positions, reset values and timing counts for the
// paged status and event register bank.
// Assumes inclusion from design files that need these constants.
`ifndef PSR_CONSTS_SVH
`define PSR_CONSTS_SVH

// Register offsets inside page 0, low seven address bits
`define PSR_OFF_WINDOW_SEL   7'h00
`define PSR_OFF_PM_STATUS    7'h01
`define PSR_OFF_PIN_LEVELS   7'h02
`define PSR_OFF_OVC_STATUS   7'h04
`define PSR_OFF_CAUSE_REC    7'h05
`define PSR_OFF_PRI_EVENTS   7'h06
`define PSR_OFF_SUP_EVENTS   7'h07
`define PSR_OFF_PIN_EVENTS   7'h08
`define PSR_OFF_PRI_MASKS    7'h0a
`define PSR_OFF_SUP_MASKS    7'h0b
`define PSR_OFF_PIN_MASKS    7'h0c

// Window select fields
`define PSR_BIT_ONE_SHOT     7
`define PSR_BIT_WRITE_STYLE  6
`define PSR_PAGE_HI          1
`define PSR_PAGE_LO          0

// Status fields
`define PSR_BIT_RAMP_ACTIVE  2
`define PSR_BIT_KEY_LEVEL    0

// Cause record fields
`define PSR_BIT_WAIT_SHUT    7
`define PSR_BIT_RESET_REQ    6
`define PSR_BIT_KEY_RESET    5
`define PSR_BIT_HEAT_CRIT    4
`define PSR_BIT_UV_EARLY     3
`define PSR_BIT_UV_ANY       2
`define PSR_BIT_COLD_START   1
`define PSR_BIT_WDOG_EXPIRY  0

// Primary event summary fields
`define PSR_BIT_SUM_PINS     6
`define PSR_BIT_SUM_SUPPLY   5

// Implemented bits of the supply events; the masks keep all eight bits
`define PSR_SUP_EVENT_BITS   8'haa

// Reset values
`define PSR_RST_WINDOW_SEL   8'h00
`define PSR_RST_MASKS        8'h00
`define PSR_RST_FLAGS        8'h00

// Early under-voltage window after reset release
`define PSR_UV_WINDOW_S      16
`define PSR_CLK_HZ           100000000
`define PSR_UV_WINDOW_CYC    (`PSR_UV_WINDOW_S * `PSR_CLK_HZ)

`endif

// >>> shared/psr_pkg.sv
// Types shared by the paged status and event register bank.
// Assumes psr_consts.svh supplies the numeric constants.
package psr_pkg;

    // One register access carried from the link to the core clock
    typedef struct packed {
        logic       write;
        logic [6:0] offset;
        logic [7:0] data;
    } psr_access_type;

    // Power-down causes, one-cycle pulses from the power logic
    typedef struct packed {
        logic wait_timeout;
        logic reset_request_cause;
        logic key_reset;
        logic critical_heat_cause;
        logic supply_uv_shutdown;
        logic cold_start;
        logic watchdog_expiry_cause;
    } psr_cause_type;

    // Event sources, one-cycle pulses from the surrounding logic
    typedef struct packed {
        logic sequencer_done_flag;
        logic watchdog_warning_flag;
        logic rtc_tick;
        logic rtc_alarm;
        logic power_key_flag;
        logic supply_uv_warning;
        logic ramp_complete_flag;
        logic regulator_overload_flag;
        logic heat_warning;
    } psr_event_type;

    // Link side parser states
    typedef enum logic [1:0] {
        PSR_ST_ADDR = 2'b01,
        PSR_ST_DATA = 2'b10
    } psr_link_state_type;

endpackage

// >>> core/psr_word_cdc.sv
// Toggle handshake that moves one word from a source to a destination
// clock. Assumes the source offers a word only while busy is low.
`timescale 1ns/1ps
`default_nettype none

module psr_word_cdc #(
    parameter int unsigned WIDTH = 16
) (
    input  wire logic             src_clk_i,
    input  wire logic             src_rst_n_i,
    input  wire logic             src_valid_i,
    input  wire logic [WIDTH-1:0] src_data_i,
    output logic                  src_busy_o,
    input  wire logic             dst_clk_i,
    input  wire logic             dst_rst_n_i,
    output logic                  dst_valid_o,
    output logic [WIDTH-1:0]      dst_data_o
);

    logic             req_q;
    logic [WIDTH-1:0] hold_q;
    logic             ack_s1_q;
    logic             ack_s2_q;
    logic             req_s1_q;
    logic             req_s2_q;
    logic             req_seen_q;

    // Source holds the word until the acknowledge toggle returns
    always_ff @(posedge src_clk_i) begin
        if (!src_rst_n_i) begin
            req_q  <= 1'b0;
            hold_q <= '0;
        end else if (src_valid_i && !src_busy_o) begin
            req_q  <= ~req_q;
            hold_q <= src_data_i;
        end
    end

    // Acknowledge back into the source clock
    always_ff @(posedge src_clk_i) begin
        if (!src_rst_n_i) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else begin
            ack_s1_q <= req_seen_q;
            ack_s2_q <= ack_s1_q;
        end
    end

    assign src_busy_o = req_q ^ ack_s2_q;

    // Request into the destination clock; the word is stable by then
    always_ff @(posedge dst_clk_i) begin
        if (!dst_rst_n_i) begin
            req_s1_q    <= 1'b0;
            req_s2_q    <= 1'b0;
            req_seen_q  <= 1'b0;
            dst_valid_o <= 1'b0;
            dst_data_o  <= '0;
        end else begin
            req_s1_q    <= req_q;
            req_s2_q    <= req_s1_q;
            req_seen_q  <= req_s2_q;
            dst_valid_o <= req_s2_q ^ req_seen_q;
            if (req_s2_q ^ req_seen_q) begin
                dst_data_o <= hold_q;
            end
        end
    end

endmodule

`default_nettype wire

// >>> tb/psr_register_bank_chk.sv
// Port checker for the paged register bank, core and link domains.
// Assumes it is bound onto psr_register_bank.
`timescale 1ns/1ps
`default_nettype none
module psr_register_bank_chk
    import psr_pkg::*;
(
    input wire logic          clk_i,
    input wire logic          rst_n_i,
    input wire logic          link_clk_i,
    input wire logic          lnk_frame_i,
    input wire logic          lnk_byte_valid_i,
    input wire logic          lnk_read_i,
    input wire logic          lnk_ready_o,
    input wire logic          lnk_rd_valid_o,
    input wire logic [7:0]    lnk_rd_data_o,
    input wire logic [4:0]    gen_input_i,
    input wire psr_event_type event_i,
    input wire logic          irq_o
);
    logic [3:0] quiet_q;
    // Quiet time: no host frame, event or pin change that may move irq
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || lnk_frame_i || event_i != '0 ||
            $changed(gen_input_i))
            quiet_q <= 4'h0;
        else if (quiet_q != 4'hf)
            quiet_q <= quiet_q + 4'h1;
    end
    irq_quiet_a:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        quiet_q > 4'h8 |-> $stable(irq_o)) else $error("irq moved idle");
    irq_reset_a:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(rst_n_i) |-> !irq_o ##1 !irq_o) else $error("irq after reset");
    rd_pulse_a:
    assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        lnk_rd_valid_o |=> !lnk_rd_valid_o) else $error("long read pulse");
    rd_answer_a:
    assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        lnk_frame_i && lnk_ready_o && lnk_read_i && !lnk_byte_valid_i
        |-> ##[1:30] lnk_rd_valid_o) else $error("read unanswered");
    rd_data_hold_a:
    assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        $changed(lnk_rd_data_o) |-> lnk_rd_valid_o) else $error("data moved");
    ready_back_a:
    assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        $fell(lnk_ready_o) |-> ##[1:40] lnk_ready_o) else $error("ready stuck");
    ready_cause_a:
    assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        $fell(lnk_ready_o) |-> $past(lnk_byte_valid_i || lnk_read_i))
        else $error("ready fell unasked");
    ready_hold_a:
    assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        lnk_ready_o && !lnk_byte_valid_i && !lnk_read_i |=> lnk_ready_o)
        else $error("ready dropped idle");
    addr_byte_a:
    assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        $rose(lnk_frame_i) ##2 (lnk_byte_valid_i && lnk_ready_o)
        |=> lnk_ready_o) else $error("address byte stalled");
endmodule
bind psr_register_bank psr_register_bank_chk chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i),
    .lnk_frame_i(lnk_frame_i), .lnk_byte_valid_i(lnk_byte_valid_i),
    .lnk_read_i(lnk_read_i), .lnk_ready_o(lnk_ready_o),
    .lnk_rd_valid_o(lnk_rd_valid_o), .lnk_rd_data_o(lnk_rd_data_o),
    .gen_input_i(gen_input_i), .event_i(event_i), .irq_o(irq_o));
`default_nettype wire

// >>> tb/psr_host_model.sv
// Host processor model on the byte link: frames, bytes, read requests.
// Assumes the bank's ready and read-reply handshake on link_clk_i.
`timescale 1ns/1ps
`default_nettype none
module psr_host_model (
    input  wire logic       link_clk_i,
    input  wire logic       ready_i,
    input  wire logic       rd_valid_i,
    input  wire logic [7:0] rd_data_i,
    output logic            frame_o,
    output logic            byte_valid_o,
    output logic [7:0]      byte_o,
    output logic            read_o
);
    int gap = 0; // Extra idle cycles, lets the bench play a slow host
    initial begin
        frame_o = 1'b0;
        byte_valid_o = 1'b0;
        byte_o = 8'h00;
        read_o = 1'b0;
    end
    // Never strobe before ready is seen high; bounded so a hang ends
    task automatic wait_rdy();
        int n;
        n = 0;
        repeat (gap + 2) @(posedge link_clk_i);
        #1;
        while (!ready_i && n < 40) begin
            @(posedge link_clk_i);
            #1;
            n++;
        end
    endtask
    task automatic frame(input logic f);
        wait_rdy();
        frame_o = f;
    endtask
    // Address or data byte, per the write style in force
    task automatic put(input logic [7:0] b);
        wait_rdy();
        byte_valid_o = 1'b1;
        byte_o = b;
        @(posedge link_clk_i);
        #1;
        byte_valid_o = 1'b0;
        byte_o = ~b; // Released bus must not keep the old value
    endtask
    task automatic get(output logic [7:0] d);
        int n;
        n = 0;
        wait_rdy();
        read_o = 1'b1;
        @(posedge link_clk_i);
        #1;
        read_o = 1'b0;
        while (!rd_valid_i && n < 40) begin
            @(posedge link_clk_i);
            #1;
            n++;
        end
        d = rd_valid_i ? rd_data_i : 8'hxx;
    endtask
endmodule
`default_nettype wire

// >>> tb/psr_register_bank_tb.sv
// Self-checking bench for the paged register bank.
// Assumes the host model, the bound checker and the shared package.
`timescale 1ns/1ps
`default_nettype none
module psr_register_bank_tb;
    import psr_pkg::*;
    logic          clk_i, rst_n_i, link_clk_i, ramp, key, sys_n, irq;
    logic          frm, bv, rq, rdy, rv;
    logic [7:0]    bw, rdat;
    logic [4:0]    gen;
    logic [3:0]    ovc;
    psr_cause_type cs;
    psr_event_type ev;
    int            checked = 0;
    int            err_total = 0;
    // Core clock 10 ns, link clock 15 ns at an unrelated phase
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        link_clk_i = 1'b0;
        #3.7;
        forever #7.5 link_clk_i = ~link_clk_i;
    end
    psr_register_bank #(.UV_WINDOW_CYC(32'd200)) dut (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .link_clk_i(link_clk_i),
        .lnk_frame_i(frm),
        .lnk_byte_valid_i(bv),
        .lnk_byte_i(bw),
        .lnk_read_i(rq),
        .lnk_ready_o(rdy),
        .lnk_rd_valid_o(rv),
        .lnk_rd_data_o(rdat),
        .voltage_ramp_active_i(ramp),
        .power_key_input_i(key),
        .gen_input_i(gen),
        .regulator_overcurrent_i(ovc),
        .system_reset_output_n_i(sys_n),
        .cause_i(cs),
        .event_i(ev),
        .irq_o(irq));
    psr_host_model host (
        .link_clk_i(link_clk_i), .ready_i(rdy), .rd_valid_i(rv),
        .rd_data_i(rdat), .frame_o(frm), .byte_valid_o(bv),
        .byte_o(bw), .read_o(rq));
    task automatic chk(input string nm, input logic [7:0] e, g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [6:0] off, input logic [7:0] d);
        host.frame(1'b1);
        host.put({1'b0, off});
        host.put(d);
        host.frame(1'b0);
    endtask
    task automatic rd(input logic [6:0] off, input logic [7:0] e);
        logic [7:0] g;
        host.frame(1'b1);
        host.put({1'b0, off});
        host.get(g);
        host.frame(1'b0);
        chk($sformatf("reg %h", off), e, g);
    endtask
    task automatic pulse(input psr_event_type e, input psr_cause_type c);
        @(posedge clk_i);
        #1;
        ev = e;
        cs = c;
        @(posedge clk_i);
        #1;
        ev = '0;
        cs = '0;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic irq_is(input logic e);
        repeat (3) @(posedge clk_i);
        #1 chk("irq", {7'h00, e}, {7'h00, irq});
    endtask
    task automatic t_masks();
        host.gap = 3;
        host.frame(1'b1);
        host.put(8'h0a);
        host.put(8'h1f);
        host.put(8'haa);
        host.put(8'h1f);
        host.frame(1'b0);
        host.gap = 0;
        rd(7'h0a, 8'h1f);
        rd(7'h0b, 8'haa);
        rd(7'h0c, 8'h1f);
    endtask
    task automatic t_events();
        pulse(9'h1ff, '0);
        irq_is(1'b0);
        rd(7'h06, 8'h3f);
        wr(7'h07, 8'h00);
        rd(7'h07, 8'haa);
        wr(7'h0a, 8'h00);
        wr(7'h0b, 8'h00);
        irq_is(1'b1);
        wr(7'h06, 8'h3f);
        rd(7'h06, 8'h20);
        irq_is(1'b1);
        wr(7'h07, 8'haa);
        rd(7'h06, 8'h00);
        irq_is(1'b0);
    endtask
    task automatic t_causes();
        pulse('0, 7'b1111011);
        rd(7'h05, 8'hf3);
        pulse('0, 7'b0000100);
        rd(7'h05, 8'hf7);
        wr(7'h05, 8'h04);
        rd(7'h05, 8'hf3);
        @(posedge clk_i) #1 sys_n = 1'b0;
        repeat (5) @(posedge clk_i);
        #1 sys_n = 1'b1;
        pulse('0, 7'b0000100);
        rd(7'h05, 8'hff);
        wr(7'h05, 8'hff);
        rd(7'h05, 8'h00);
    endtask
    task automatic t_status();
        @(posedge clk_i);
        #1;
        {ramp, key, gen, ovc} = {2'b11, 5'h15, 4'ha};
        repeat (6) @(posedge clk_i);
        rd(7'h01, 8'h05);
        rd(7'h02, 8'h15);
        rd(7'h04, 8'h0a);
        rd(7'h08, 8'h15);
        rd(7'h06, 8'h40);
        wr(7'h08, 8'h15);
        rd(7'h08, 8'h00);
    endtask
    task automatic t_pages();
        wr(7'h00, 8'h01);
        rd(7'h00, 8'h01);
        rd(7'h0c, 8'h00);
        wr(7'h00, 8'h83);
        rd(7'h00, 8'h83);
        rd(7'h0c, 8'h00);
        rd(7'h0c, 8'h1f);
        rd(7'h00, 8'h80);
        wr(7'h00, 8'h40);
        host.frame(1'b1);
        host.put(8'h0a);
        host.put(8'h11);
        host.put(8'h0c);
        host.put(8'h03);
        host.put(8'h0b);
        host.frame(1'b0);
        rd(7'h0a, 8'h11);
        rd(7'h0c, 8'h03);
        rd(7'h0b, 8'h00);
    endtask
    task automatic results();
        $display("checked %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Inputs idle at time zero, reset held 20 core cycles
    initial begin
        {rst_n_i, ramp, key, sys_n, gen, ovc} = {4'b0001, 9'h000};
        cs = '0;
        ev = '0;
        repeat (20) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        repeat (10) @(posedge clk_i);
        for (int o = 0; o < 13; o++) rd(7'(o), 8'h00);
        t_masks();
        t_events();
        t_causes();
        t_status();
        t_pages();
        results();
    end
    // Far beyond what the tests need
    initial begin
        #500000;
        err_total++;
        results();
    end
endmodule
`default_nettype wire
